// ===== core/slm_data_handler.sv
`timescale 1ns/1ps

// What this block does
// - Eight or sixteen lines reach host memory both ways.
// - Receivers assemble bits and flag each character.
// - Transmitters serialise and flag when ready for more.
// - Scanner presents each line's flags; sequencer advances it.
// - Started by the host, the sequencer runs nonstop.
// - Received characters queue in a FIFO of up to 128.
// - A character entering an empty FIFO shows at its output.
// - Head character indexes the control table, read by memory request.
// - A storing control byte writes the character to memory while the receive count is not zero.
// - An interrupt character is held and interrupts the host.
// - Holding register shows character, line and error flag.
// - While held: FIFO fills, receive waits, transmit goes on.
// - Per-line storage keeps addresses and byte counts.
// - Per-line storage keeps protocol settings.
// - Transmit flag: fetch character, fetch control byte, act, load.
// - Control characters recorded, sequence kept, block check summed.
// - An answered outgoing call raises a modem interrupt.
// - A ring indication raises a modem interrupt.
module slm_data_handler #(
  parameter int NUM_LINES = 16,
  parameter int FIFO_DEPTH = 128
) (
  // Clock and reset.
  input logic ref_clk,
  input logic arst_n,
  // Serial lines, one bit strobe per line from the line timing.
  input logic [NUM_LINES-1:0] rx_bit,
  input logic [NUM_LINES-1:0] rx_bit_stb,
  input logic [NUM_LINES-1:0] tx_bit_stb,
  output logic [NUM_LINES-1:0] tx_serial,
  // Host control.
  input logic host_start,
  input logic host_resume,
  input logic host_resume_store,
  input logic [NUM_LINES-1:0] overrun_clr,
  output logic [NUM_LINES-1:0] overrun_flag,
  // Per-line storage port.
  input logic cfg_we,
  input logic [slm_pkg::LINE_W-1:0] cfg_line,
  input logic [3:0] cfg_sel,
  input logic [slm_pkg::ADDR_W-1:0] cfg_wdata,
  output logic [slm_pkg::ADDR_W-1:0] cfg_rdata,
  // Interrupt character holding register.
  output slm_pkg::slm_rx_entry_s interrupt_char_holding_reg,
  output logic char_irq,
  // Direct memory request port, byte wide.
  output logic direct_memory_request,
  output logic dma_we,
  output logic [slm_pkg::ADDR_W-1:0] dma_addr,
  output logic [slm_pkg::CHAR_BITS-1:0] dma_wdata,
  input logic dma_ack,
  input logic [slm_pkg::CHAR_BITS-1:0] dma_rdata,
  // Modem control.
  input logic [NUM_LINES-1:0] modem_ring,
  input logic [NUM_LINES-1:0] modem_answer,
  input logic modem_ack,
  output logic modem_irq,
  output logic [slm_pkg::LINE_W-1:0] modem_line,
  output slm_pkg::slm_modem_ev_e modem_kind
);

  localparam int CW = slm_pkg::CHAR_BITS;
  localparam int AW = slm_pkg::ADDR_W;
  localparam int NW = slm_pkg::CNT_W;
  localparam int LW = slm_pkg::LINE_W;
  localparam int EW = $bits(slm_pkg::slm_rx_entry_s);

  typedef enum {S_STOP, S_SCAN, S_RX_CTL, S_RX_STORE, S_TX_FETCH, S_TX_CTL,
                S_TX_LOAD} slm_state_e;

  // ==========================================================================
  // Reset release.
  logic [1:0] rst_sync_q;
  logic rst_n;

  // Two stages so the release is clean against ref_clk.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ==========================================================================
  // Shared state.
  slm_state_e state_q;
  logic [LW-1:0] scan_q;
  logic [LW-1:0] cur_line_q;
  logic [CW-1:0] cur_char_q;
  logic [CW-1:0] ctl_q;
  logic held_q;
  logic from_hold_q;
  logic resume_pend_q;
  logic resume_store_q;
  logic [NUM_LINES-1:0] rx_flag_q;
  logic [NUM_LINES-1:0] tx_busy_q;
  logic [NUM_LINES-1:0] rx_take;
  logic [NUM_LINES-1:0] tx_load;
  logic [CW-1:0] rx_buf_q [NUM_LINES];
  logic [AW-1:0] rx_addr_q [NUM_LINES];
  logic [NW-1:0] rx_cnt_q [NUM_LINES];
  logic [AW-1:0] tx_addr_q [NUM_LINES];
  logic [NW-1:0] tx_cnt_q [NUM_LINES];
  logic [AW-1:0] rx_tbl_q [NUM_LINES];
  logic [AW-1:0] tx_tbl_q [NUM_LINES];
  logic [slm_pkg::PROTO_W-1:0] proto_q [NUM_LINES];
  logic [slm_pkg::BCC_W-1:0] bcc_rx_q [NUM_LINES];
  logic [slm_pkg::BCC_W-1:0] bcc_tx_q [NUM_LINES];
  logic [15:0] seq_q [NUM_LINES];
  logic [NUM_LINES-1:0] ring_q;
  logic [NUM_LINES-1:0] answer_q;

  // ==========================================================================
  // Received character FIFO.
  slm_pkg::slm_rx_entry_s fifo_in;
  slm_pkg::slm_rx_entry_s fifo_out;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [EW-1:0] fifo_out_bits;
  logic rx_ctl_done;
  logic rx_keep;

  // The scanned line hands its character to the FIFO even while held.
  assign fifo_in_valid = (state_q == S_SCAN) && rx_flag_q[scan_q];
  assign fifo_in = '{line: scan_q, err: overrun_flag[scan_q], char_code: rx_buf_q[scan_q]};
  assign fifo_out = slm_pkg::slm_rx_entry_s'(fifo_out_bits);
  assign rx_ctl_done = (state_q == S_RX_CTL) && dma_ack;
  assign rx_keep = dma_rdata[slm_pkg::CB_STORE] && (rx_cnt_q[cur_line_q] != '0);
  // The head leaves once it is stored, held or dropped.
  assign fifo_pop = (rx_ctl_done && (dma_rdata[slm_pkg::CB_INTR] || !rx_keep)) ||
                    ((state_q == S_RX_STORE) && dma_ack && !from_hold_q);

  slm_fifo #(.WIDTH(EW), .DEPTH(FIFO_DEPTH)) u_received_char_fifo (
    .clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_bits)
  );

  // ==========================================================================
  // Receivers and transmitters, one set per line.
  genvar g;
  for (g = 0; g < NUM_LINES; g++) begin : g_line
    logic [CW-1:0] rx_sh_q;
    logic [slm_pkg::BCNT_W-1:0] rx_bc_q;
    logic [CW-1:0] tx_sh_q;
    logic [slm_pkg::BCNT_W-1:0] tx_bc_q;
    logic rx_done;

    assign rx_done = rx_bit_stb[g] && (rx_bc_q == slm_pkg::BCNT_W'(CW-1));
    assign rx_take[g] = (state_q == S_SCAN) && (scan_q == LW'(g));
    assign tx_load[g] = (state_q == S_TX_LOAD) && (cur_line_q == LW'(g));

    // Least significant bit first; a new character wins over the take.
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        rx_sh_q <= '0;
        rx_bc_q <= '0;
        rx_buf_q[g] <= '0;
        rx_flag_q[g] <= 1'b0;
      end else begin
        if (rx_bit_stb[g]) begin
          rx_sh_q <= {rx_bit[g], rx_sh_q[CW-1:1]};
          rx_bc_q <= rx_done ? '0 : rx_bc_q + 1'b1;
        end
        if (rx_done) begin
          rx_buf_q[g] <= {rx_bit[g], rx_sh_q[CW-1:1]};
        end
        rx_flag_q[g] <= rx_done || (rx_flag_q[g] && !rx_take[g]);
      end
    end

    // The line starts at mark after reset and then keeps the last bit sent; the ready flag is simply not busy.
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        tx_sh_q <= '0;
        tx_bc_q <= '0;
        tx_busy_q[g] <= 1'b0;
        tx_serial[g] <= 1'b1;
      end else if (tx_load[g]) begin
        tx_sh_q <= cur_char_q;
        tx_bc_q <= '0;
        tx_busy_q[g] <= 1'b1;
      end else if (tx_busy_q[g] && tx_bit_stb[g]) begin
        tx_serial[g] <= tx_sh_q[0];
        tx_sh_q <= {1'b0, tx_sh_q[CW-1:1]};
        tx_bc_q <= tx_bc_q + 1'b1;
        tx_busy_q[g] <= (tx_bc_q != slm_pkg::BCNT_W'(CW-1));
      end
    end
  end

  // Overrun: a character that finds the FIFO full is lost; the set wins.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_flag <= '0;
    end else begin
      for (int i = 0; i < NUM_LINES; i++) begin
        if (rx_take[i] && rx_flag_q[i] && !fifo_in_ready) begin
          overrun_flag[i] <= 1'b1;
        end else if (overrun_clr[i]) begin
          overrun_flag[i] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // Block check update, one byte, reflected CRC.
  function automatic logic [slm_pkg::BCC_W-1:0] bcc_next(
    input logic [slm_pkg::BCC_W-1:0] c, input logic [CW-1:0] d);
    logic [slm_pkg::BCC_W-1:0] r;
    r = c ^ {{(slm_pkg::BCC_W-CW){1'b0}}, d};
    for (int b = 0; b < CW; b++) begin
      r = r[0] ? ((r >> 1) ^ slm_pkg::BCC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // ==========================================================================
  // Sequencer: scanner, control table lookup and memory transfers.
  // Host start latches run; nothing stops it short of reset.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_STOP;
      scan_q <= '0;
      cur_line_q <= '0;
      cur_char_q <= '0;
      ctl_q <= '0;
      from_hold_q <= 1'b0;
      direct_memory_request <= 1'b0;
      dma_we <= 1'b0;
      dma_addr <= slm_pkg::ADDR_RST;
      dma_wdata <= '0;
    end else begin
      case (state_q)
        S_STOP: begin
          if (host_start) begin
            state_q <= S_SCAN;
          end
        end
        S_SCAN: begin
          scan_q <= (scan_q == LW'(NUM_LINES-1)) ? '0 : scan_q + 1'b1;
          if (resume_pend_q && held_q && resume_store_q) begin
            cur_line_q <= interrupt_char_holding_reg.line;
            from_hold_q <= 1'b1;
            direct_memory_request <= 1'b1;
            dma_we <= 1'b1;
            dma_addr <= rx_addr_q[interrupt_char_holding_reg.line];
            dma_wdata <= interrupt_char_holding_reg.char_code;
            state_q <= S_RX_STORE;
          end else if (fifo_out_valid && !held_q && !resume_pend_q &&
                       proto_q[fifo_out.line][slm_pkg::PR_RX_EN]) begin
            cur_line_q <= fifo_out.line;
            cur_char_q <= fifo_out.char_code;
            from_hold_q <= 1'b0;
            direct_memory_request <= 1'b1;
            dma_we <= 1'b0;
            dma_addr <= rx_tbl_q[fifo_out.line] + AW'(fifo_out.char_code);
            state_q <= S_RX_CTL;
          end else if (!tx_busy_q[scan_q] && proto_q[scan_q][slm_pkg::PR_TX_EN] &&
                       (tx_cnt_q[scan_q] != '0)) begin
            cur_line_q <= scan_q;
            direct_memory_request <= 1'b1;
            dma_we <= 1'b0;
            dma_addr <= tx_addr_q[scan_q];
            state_q <= S_TX_FETCH;
          end
        end
        S_RX_CTL: begin
          if (dma_ack) begin
            if (!dma_rdata[slm_pkg::CB_INTR] && rx_keep) begin
              dma_we <= 1'b1;
              dma_addr <= rx_addr_q[cur_line_q];
              dma_wdata <= cur_char_q;
              state_q <= S_RX_STORE;
            end else begin
              direct_memory_request <= 1'b0;
              state_q <= S_SCAN;
            end
          end
        end
        S_RX_STORE: begin
          if (dma_ack) begin
            direct_memory_request <= 1'b0;
            dma_we <= 1'b0;
            state_q <= S_SCAN;
          end
        end
        S_TX_FETCH: begin
          if (dma_ack) begin
            cur_char_q <= dma_rdata;
            dma_addr <= tx_tbl_q[cur_line_q] + AW'(dma_rdata);
            state_q <= S_TX_CTL;
          end
        end
        S_TX_CTL: begin
          if (dma_ack) begin
            ctl_q <= dma_rdata;
            direct_memory_request <= 1'b0;
            state_q <= S_TX_LOAD;
          end
        end
        S_TX_LOAD: begin
          state_q <= S_SCAN;
        end
        default: begin
          state_q <= S_STOP;
        end
      endcase
    end
  end

  // Holding register; a resume arriving with a new hold is not lost.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      held_q <= 1'b0;
      char_irq <= 1'b0;
      resume_pend_q <= 1'b0;
      resume_store_q <= 1'b0;
      interrupt_char_holding_reg <= '0;
    end else begin
      if (host_resume) begin
        resume_pend_q <= 1'b1;
        resume_store_q <= host_resume_store;
      end else if (state_q == S_SCAN) begin
        resume_pend_q <= 1'b0;
      end
      if (rx_ctl_done && dma_rdata[slm_pkg::CB_INTR]) begin
        interrupt_char_holding_reg <= fifo_out;
        held_q <= 1'b1;
        char_irq <= 1'b1;
      end else if (state_q == S_SCAN && resume_pend_q && !host_resume) begin
        held_q <= 1'b0;
        char_irq <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Per-line storage: host writes, sequencer counts and checks.
  // A sequencer update of the same line and word wins over a host write.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata <= '0;
      for (int i = 0; i < NUM_LINES; i++) begin
        rx_addr_q[i] <= slm_pkg::ADDR_RST;
        tx_addr_q[i] <= slm_pkg::ADDR_RST;
        rx_tbl_q[i] <= slm_pkg::ADDR_RST;
        tx_tbl_q[i] <= slm_pkg::ADDR_RST;
        rx_cnt_q[i] <= slm_pkg::CNT_RST;
        tx_cnt_q[i] <= slm_pkg::CNT_RST;
        proto_q[i] <= '0;
        bcc_rx_q[i] <= slm_pkg::BCC_INIT;
        bcc_tx_q[i] <= slm_pkg::BCC_INIT;
        seq_q[i] <= '0;
      end
    end else begin
      if (cfg_we) begin
        case (cfg_sel)
          slm_pkg::SEL_RX_ADDR: rx_addr_q[cfg_line] <= cfg_wdata;
          slm_pkg::SEL_RX_CNT: rx_cnt_q[cfg_line] <= cfg_wdata[NW-1:0];
          slm_pkg::SEL_TX_ADDR: tx_addr_q[cfg_line] <= cfg_wdata;
          slm_pkg::SEL_TX_CNT: tx_cnt_q[cfg_line] <= cfg_wdata[NW-1:0];
          slm_pkg::SEL_RX_TBL: rx_tbl_q[cfg_line] <= cfg_wdata;
          slm_pkg::SEL_TX_TBL: tx_tbl_q[cfg_line] <= cfg_wdata;
          slm_pkg::SEL_PROTO: proto_q[cfg_line] <= cfg_wdata[slm_pkg::PROTO_W-1:0];
          slm_pkg::SEL_BCC_RX: bcc_rx_q[cfg_line] <= cfg_wdata[slm_pkg::BCC_W-1:0];
          slm_pkg::SEL_BCC_TX: bcc_tx_q[cfg_line] <= cfg_wdata[slm_pkg::BCC_W-1:0];
          slm_pkg::SEL_SEQ: seq_q[cfg_line] <= cfg_wdata[15:0];
          default: ;
        endcase
      end
      case (cfg_sel)
        slm_pkg::SEL_RX_ADDR: cfg_rdata <= rx_addr_q[cfg_line];
        slm_pkg::SEL_RX_CNT: cfg_rdata <= AW'(rx_cnt_q[cfg_line]);
        slm_pkg::SEL_TX_ADDR: cfg_rdata <= tx_addr_q[cfg_line];
        slm_pkg::SEL_TX_CNT: cfg_rdata <= AW'(tx_cnt_q[cfg_line]);
        slm_pkg::SEL_RX_TBL: cfg_rdata <= rx_tbl_q[cfg_line];
        slm_pkg::SEL_TX_TBL: cfg_rdata <= tx_tbl_q[cfg_line];
        slm_pkg::SEL_PROTO: cfg_rdata <= AW'(proto_q[cfg_line]);
        slm_pkg::SEL_BCC_RX: cfg_rdata <= AW'(bcc_rx_q[cfg_line]);
        slm_pkg::SEL_BCC_TX: cfg_rdata <= AW'(bcc_tx_q[cfg_line]);
        slm_pkg::SEL_SEQ: cfg_rdata <= AW'(seq_q[cfg_line]);
        default: cfg_rdata <= '0;
      endcase
      // Receive store advances the pointer and spends one count.
      if (state_q == S_RX_STORE && dma_ack) begin
        rx_addr_q[cur_line_q] <= rx_addr_q[cur_line_q] + 1'b1;
        rx_cnt_q[cur_line_q] <= rx_cnt_q[cur_line_q] - 1'b1;
      end
      // An inspected received character feeds the check when enabled and not excluded, and the sequence record when marked protocol.
      if (rx_ctl_done) begin
        if (proto_q[cur_line_q][slm_pkg::PR_BCC_EN] && !dma_rdata[slm_pkg::CB_NOBCC]) begin
          bcc_rx_q[cur_line_q] <= bcc_next(bcc_rx_q[cur_line_q], cur_char_q);
        end
        if (dma_rdata[slm_pkg::CB_PROTO]) begin
          seq_q[cur_line_q] <= {cur_char_q, seq_q[cur_line_q][7:0] + 8'h01};
        end
      end
      // The transmit side does the same when the transmitter is loaded.
      if (state_q == S_TX_LOAD) begin
        tx_addr_q[cur_line_q] <= tx_addr_q[cur_line_q] + 1'b1;
        tx_cnt_q[cur_line_q] <= tx_cnt_q[cur_line_q] - 1'b1;
        if (proto_q[cur_line_q][slm_pkg::PR_BCC_EN] && !ctl_q[slm_pkg::CB_NOBCC]) begin
          bcc_tx_q[cur_line_q] <= bcc_next(bcc_tx_q[cur_line_q], cur_char_q);
        end
        if (ctl_q[slm_pkg::CB_PROTO]) begin
          seq_q[cur_line_q] <= {cur_char_q, seq_q[cur_line_q][7:0] + 8'h01};
        end
      end
    end
  end

  // ==========================================================================
  // Modem control: rising edges of ring and answer; the lowest line wins.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ring_q <= '0;
      answer_q <= '0;
      modem_irq <= 1'b0;
      modem_line <= '0;
      modem_kind <= slm_pkg::SLM_EV_ANSWER;
    end else begin
      ring_q <= modem_ring;
      answer_q <= modem_answer;
      if (modem_ack) begin
        modem_irq <= 1'b0;
      end
      // Events while one is pending are dropped; the host polls the modem lines.
      for (int i = NUM_LINES - 1; i >= 0; i--) begin
        if (!modem_irq && modem_answer[i] && !answer_q[i]) begin
          modem_irq <= 1'b1;
          modem_line <= LW'(i);
          modem_kind <= slm_pkg::SLM_EV_ANSWER;
        end else if (!modem_irq && modem_ring[i] && !ring_q[i]) begin
          modem_irq <= 1'b1;
          modem_line <= LW'(i);
          modem_kind <= slm_pkg::SLM_EV_RING;
        end
      end
    end
  end

endmodule

// ===== core/slm_pkg.sv
package slm_pkg;

  // ==========================================================================
  // Line and character geometry.
  localparam int MAX_LINES = 16;
  localparam int LINE_W = 4;
  localparam int CHAR_BITS = 8;
  localparam int BCNT_W = 3;
  localparam int ADDR_W = 18;
  localparam int CNT_W = 16;
  localparam int BCC_W = 16;

  // ==========================================================================
  // Control byte fields.
  localparam int CB_STORE = 0;
  localparam int CB_INTR = 1;
  localparam int CB_PROTO = 2;
  localparam int CB_NOBCC = 3;

  // ==========================================================================
  // Per-line protocol control bits.
  localparam int PR_RX_EN = 0;
  localparam int PR_TX_EN = 1;
  localparam int PR_BCC_EN = 2;
  localparam int PROTO_W = 3;

  // ==========================================================================
  // Per-line storage select codes on the configuration port.
  localparam logic [3:0] SEL_RX_ADDR = 4'h0;
  localparam logic [3:0] SEL_RX_CNT = 4'h1;
  localparam logic [3:0] SEL_TX_ADDR = 4'h2;
  localparam logic [3:0] SEL_TX_CNT = 4'h3;
  localparam logic [3:0] SEL_RX_TBL = 4'h4;
  localparam logic [3:0] SEL_TX_TBL = 4'h5;
  localparam logic [3:0] SEL_PROTO = 4'h6;
  localparam logic [3:0] SEL_BCC_RX = 4'h7;
  localparam logic [3:0] SEL_BCC_TX = 4'h8;
  localparam logic [3:0] SEL_SEQ = 4'h9;

  // ==========================================================================
  // Reset values and block check polynomial (reflected form).
  localparam logic [BCC_W-1:0] BCC_POLY = 16'ha001;
  localparam logic [BCC_W-1:0] BCC_INIT = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

  // ==========================================================================
  // One received character with its line and error flag.
  typedef struct packed {
    logic [LINE_W-1:0] line;
    logic err;
    logic [CHAR_BITS-1:0] char_code;
  } slm_rx_entry_s;

  // Modem event kinds.
  typedef enum logic {SLM_EV_ANSWER, SLM_EV_RING} slm_modem_ev_e;

endpackage

// ===== core/slm_fifo.sv
`timescale 1ns/1ps

module slm_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input logic clk,
  input logic rst_n,
  // Filling side.
  input logic in_valid,
  output logic in_ready,
  input logic [WIDTH-1:0] in_data,
  // Draining side, first word falls through.
  output logic out_valid,
  input logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] cnt_q;
  logic push;
  logic pop;

  // Honest flags; the head is read straight from storage so it shows at once.
  assign in_ready = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage array needs no reset.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // Pointers wrap at the depth, so any depth from two up works.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule

// ===== tb/slm_monitor.sv
`timescale 1ns/1ps
// ============================================================
// Port checks on the memory request, the held character and modem events.
module slm_monitor #(
  parameter int NUM_LINES = 16
) (
  // Clock and reset.
  input logic ref_clk,
  input logic arst_n,
  // Watched ports.
  input logic direct_memory_request,
  input logic dma_we,
  input logic [slm_pkg::ADDR_W-1:0] dma_addr,
  input logic dma_ack,
  input logic char_irq,
  input slm_pkg::slm_rx_entry_s interrupt_char_holding_reg,
  input logic [NUM_LINES-1:0] overrun_flag,
  input logic [NUM_LINES-1:0] overrun_clr,
  input logic modem_ack,
  input logic modem_irq,
  input logic [slm_pkg::LINE_W-1:0] modem_line,
  input slm_pkg::slm_modem_ev_e modem_kind
);
  // One clock domain, so clocking and disable are given once.
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_req_hold; direct_memory_request && !dma_ack |=> direct_memory_request && $stable(dma_addr) && $stable(dma_we); endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed before ack");
  property p_req_drop; $fell(direct_memory_request) |-> $past(dma_ack); endproperty
  a_req_drop: assert property (p_req_drop) else $error("request dropped without ack");
  property p_no_store_held; char_irq |-> !(direct_memory_request && dma_we); endproperty
  a_no_store_held: assert property (p_no_store_held) else $error("store while held");
  property p_hold_keep; $rose(char_irq) |=> $stable(interrupt_char_holding_reg); endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("holding reg moved");
  property p_ovr_keep; 1 |=> (overrun_flag & $past(overrun_flag & ~overrun_clr)) == $past(overrun_flag & ~overrun_clr); endproperty
  a_ovr_keep: assert property (p_ovr_keep) else $error("overrun flag lost");
  property p_modem_keep; modem_irq && !modem_ack |=> modem_irq; endproperty
  a_modem_keep: assert property (p_modem_keep) else $error("modem irq lost");
  property p_modem_clr; modem_ack |=> !modem_irq; endproperty
  a_modem_clr: assert property (p_modem_clr) else $error("modem irq not cleared");
  property p_modem_info; modem_irq && !modem_ack |=> $stable(modem_line) && $stable(modem_kind); endproperty
  a_modem_info: assert property (p_modem_info) else $error("modem event info moved");
endmodule
bind slm_data_handler slm_monitor #(.NUM_LINES(NUM_LINES)) slm_monitor_inst (.*);

// ===== tb/slm_mem_model.sv
`timescale 1ns/1ps
// ============================================================
// Byte-wide host memory answering direct memory requests.
module slm_mem_model (
  // Clock and memory port.
  input logic clk,
  input logic req,
  input logic we,
  input logic [17:0] addr,
  input logic [7:0] wdata,
  output logic ack,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:1023]; // Control tables and buffers, one byte per code.
  logic [1:0] wait_q = 2'h0;
  logic slow_q = 1'b0;
  initial foreach (mem[i]) mem[i] = 8'h00;
  initial {ack, rdata} = 9'h000;
  // Prompt and slow answers alternate; rdata scrambles off the ack.
  always @(negedge clk) begin
    ack <= 1'b0;
    rdata <= ~rdata;
    if (req && !ack && wait_q != 2'h0) wait_q <= wait_q - 2'h1;
    else if (req && !ack) begin
      ack <= 1'b1;
      rdata <= mem[addr[9:0]];
      if (we) mem[addr[9:0]] <= wdata;
      wait_q <= slow_q ? 2'h3 : 2'h0;
      slow_q <= !slow_q;
    end
  end
endmodule

// ===== tb/slm_data_handler_test.sv
`timescale 1ns/1ps
// ============================================================
// Receive store, held character with overrun, modem events, transmit.
module slm_data_handler_test;
  logic ref_clk = 1'b0, arst_n = 1'b0, host_start = 1'b0, host_resume = 1'b0;
  logic host_resume_store = 1'b0, modem_ack = 1'b0, cfg_we = 1'b0;
  logic [15:0] rx_bit = '0, rx_bit_stb = '0, overrun_clr = '0, modem_ring = '0, modem_answer = '0;
  logic [15:0] overrun_flag, tx_serial, tx_bit_stb = '0;
  logic [3:0] cfg_line = '0, cfg_sel = '0, modem_line;
  logic [17:0] cfg_wdata = '0, cfg_rdata, dma_addr;
  logic [7:0] dma_wdata, dma_rdata;
  logic char_irq, direct_memory_request, dma_we, dma_ack, modem_irq;
  slm_pkg::slm_rx_entry_s interrupt_char_holding_reg;
  slm_pkg::slm_modem_ev_e modem_kind;
  int miscompares = 0, checks = 0;
  slm_data_handler #(.FIFO_DEPTH(4)) slm_data_handler_inst (.*);
  slm_mem_model slm_mem_model_inst (.clk(ref_clk), .req(direct_memory_request), .we(dma_we),
    .addr(dma_addr), .wdata(dma_wdata), .ack(dma_ack), .rdata(dma_rdata));
  // Free-running 250 MHz clock.
  always #2 ref_clk = ~ref_clk;
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cfg(input logic [3:0] l, input logic [3:0] s, input logic [17:0] d);
    @(negedge ref_clk);
    {cfg_we, cfg_line, cfg_sel, cfg_wdata} = {1'b1, l, s, d};
    @(negedge ref_clk);
    cfg_we = 1'b0;
  endtask
  // Eight strobed bits, lowest first; the data line scrambles between strobes.
  task automatic send(input logic [3:0] l, input logic [7:0] c);
    for (int i = 0; i < 8; i++) begin
      @(negedge ref_clk);
      {rx_bit[l], rx_bit_stb[l]} = {c[i], 1'b1};
      @(negedge ref_clk);
      {rx_bit[l], rx_bit_stb[l]} = {~c[i], 1'b0};
    end
  endtask
  task automatic till(ref logic s);
    for (int i = 0; i < 400 && s !== 1'b1; i++) @(negedge ref_clk);
  endtask
  task automatic wait_mem(input logic [9:0] a, input logic [7:0] c);
    for (int i = 0; i < 400 && slm_mem_model_inst.mem[a] !== c; i++) @(negedge ref_clk);
    chk(18'(slm_mem_model_inst.mem[a]), 18'(c));
  endtask
  task automatic rd(input logic [3:0] s, input logic [17:0] exp);
    {cfg_line, cfg_sel} = {4'h0, s};
    repeat (2) @(negedge ref_clk);
    chk(cfg_rdata, exp);
  endtask
  task automatic t_store;
    slm_mem_model_inst.mem[10'h141] = 8'h01;
    slm_mem_model_inst.mem[10'h15a] = 8'h02;
    cfg(4'h0, slm_pkg::SEL_PROTO, 18'h00001);
    cfg(4'h0, slm_pkg::SEL_RX_TBL, 18'h00100);
    cfg(4'h0, slm_pkg::SEL_RX_ADDR, 18'h00200);
    cfg(4'h0, slm_pkg::SEL_RX_CNT, 18'h00010);
    host_start = 1'b1;
    @(negedge ref_clk);
    host_start = 1'b0;
    send(4'h0, 8'h41);
    wait_mem(10'h200, 8'h41);
    rd(slm_pkg::SEL_RX_ADDR, 18'h00201);
    rd(slm_pkg::SEL_RX_CNT, 18'h0000f);
  endtask
  // Held character: the FIFO fills and overflows while storing waits.
  task automatic t_hold;
    send(4'h0, 8'h5a);
    till(char_irq);
    chk(18'(interrupt_char_holding_reg), 18'h0005a);
    repeat (5) send(4'h0, 8'h41);
    repeat (60) @(negedge ref_clk);
    chk(18'(overrun_flag), 18'h00001);
    chk(18'(slm_mem_model_inst.mem[10'h201]), 18'h00000);
    {host_resume, host_resume_store, overrun_clr} = {2'b11, 16'h0001};
    @(negedge ref_clk);
    {host_resume, overrun_clr} = {1'b0, 16'h0000};
    wait_mem(10'h201, 8'h5a);
    wait_mem(10'h205, 8'h41);
    chk({char_irq, overrun_flag}, 18'h00000);
  endtask
  task automatic t_modem;
    modem_ring[3] = 1'b1;
    till(modem_irq);
    chk(18'({modem_kind, modem_line}), 18'h00013);
    modem_ack = 1'b1;
    @(negedge ref_clk);
    {modem_ack, modem_answer[5]} = 2'b01;
    till(modem_irq);
    chk(18'({modem_kind, modem_line}), 18'h00005);
  endtask
  task automatic t_tx;
    logic [7:0] c = 8'h6c;
    slm_mem_model_inst.mem[10'h000] = c;
    cfg(4'h0, slm_pkg::SEL_TX_CNT, 18'h00001);
    cfg(4'h0, slm_pkg::SEL_PROTO, 18'h00003);
    for (int i = 0; i < 8; i++) begin
      repeat (40) @(negedge ref_clk);
      tx_bit_stb[0] = 1'b1;
      @(negedge ref_clk);
      tx_bit_stb[0] = 1'b0;
      chk(18'(tx_serial[0]), 18'(c[i]));
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Main sequence after eight reset cycles.
  initial begin
    repeat (8) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    t_store;
    t_hold;
    t_modem;
    t_tx;
    end_of_test;
  end
  // Watchdog far beyond what the scenarios need.
  initial begin
    #100000;
    miscompares++;
    end_of_test;
  end
endmodule
